// [logic/gdff_ack_pulse.sv]
// Acknowledge pulse stretcher: a one-cycle trigger gives a pulse of ack_len cycles.
// Assumes synchronous trigger and a shared clock enable.
`timescale 1ns/1ns
module gdff_ack_pulse #(
  parameter int unsigned CNT_W = 24
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             trig,
  input  wire logic [CNT_W-1:0] ack_len,
  output logic                  pulse
);
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (trig) begin
        cnt_reg <= ack_len;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign pulse = (cnt_reg != '0);
endmodule // gdff_ack_pulse

// [logic/gdff_pkg.sv]
// Package of timing constants for the dual-channel gate drive fault feedback block.
// Assumes a 125 MHz core clock; all counts are derived from times in ns.
package gdff_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned ACK_TIME_NS     = 700;
  localparam int unsigned CLEAR_TIME_NS   = 11000;
  localparam int unsigned SHUT_TIME_NS    = 1400;
  localparam int unsigned RESP_TIME_NS    = 4000;
  localparam int unsigned SO_HOLD_TIME_NS = 90000000;
  localparam int unsigned ACK_CYCLES      = ACK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_CYCLES    = CLEAR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SHUT_CYCLES     = SHUT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned RESP_CYCLES     = RESP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SO_HOLD_CYCLES  = SO_HOLD_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CHANNELS        = 2;
  localparam int unsigned CNT_W           = 24;

  typedef enum logic [4:0] {
    GDFF_ST_OFF   = 5'b00001,
    GDFF_ST_RESP  = 5'b00010,
    GDFF_ST_ON    = 5'b00100,
    GDFF_ST_SHUT  = 5'b01000,
    GDFF_ST_CLEAR = 5'b10000
  } gdff_state_t;
endpackage

// [logic/gdff_supply_status.sv]
// Primary supply status pin: held low during undervoltage and for a hold time after.
// Assumes an open-drain pin with an external pull-up; oe_n low means driving low.
`timescale 1ns/1ns
module gdff_supply_status #(
  parameter int unsigned HOLD = gdff_pkg::SO_HOLD_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic prim_uv,
  output logic      so_out,
  output logic      so_oe_n
);
  import gdff_pkg::*;
  localparam int W = $clog2(HOLD + 1);
  logic [W-1:0] hold_reg;
  logic         low_reg;

  initial begin
    if (HOLD < 1) $error("HOLD must be at least one cycle.");
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= '0;
      low_reg  <= 1'b1;
    end else if (clk_en) begin
      if (prim_uv) begin
        hold_reg <= W'(HOLD);
        low_reg  <= 1'b1;  // [R8]
      end else if (hold_reg != '0) begin
        hold_reg <= hold_reg - 1'b1;
        low_reg  <= 1'b1;
      end else begin
        low_reg  <= 1'b0;  // [R9]
      end
    end
  end

  assign so_out  = 1'b0;
  assign so_oe_n = ~low_reg;  // [R8]
endmodule // gdff_supply_status

// [logic/gdff_top.sv]
// Dual-channel gate drive control with optical status feedback and supply status pin.
// Assumes all inputs synchronous to core_clk; Vce comparison done outside.
// Summary of operation
// R1: Status light on when healthy, off on fault.
// R2: Each input edge blanks status about 700ns.
// R3: Short circuit blanks status for clearing delay.
// R4: Gate off 1.4us after response time.
// R5: Restart only on new rising input edge.
// R6: Secondary undervoltage holds fault and lock.
// R7: Fault shown at power-up until supply good.
// R8: Status pin open when good, low otherwise.
// R9: Status pin releases 90ms after undervoltage ends.
// R10: Primary undervoltage never blocks the channels.
// R11: Secondary undervoltage blocks with negative gate drive.
// R12: Channels independent, no interlock or dead time.
// R13: Gate follows input high on, low off, except during shutdown and clear delays.
// R14: Check desaturation after response time at turn-on.
// R15: Timing values are cycle-count parameters.
`timescale 1ns/1ns
module gdff_top #(
  parameter int unsigned RESP_CYC  = gdff_pkg::RESP_CYCLES,
  parameter int unsigned ACK_CYC   = gdff_pkg::ACK_CYCLES,
  parameter int unsigned CLEAR_CYC = gdff_pkg::CLEAR_CYCLES,
  parameter int unsigned SHUT_CYC  = gdff_pkg::SHUT_CYCLES,
  parameter int unsigned SO_HOLD   = gdff_pkg::SO_HOLD_CYCLES
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic [gdff_pkg::CHANNELS-1:0] drive_in,
  input  wire logic [gdff_pkg::CHANNELS-1:0] vce_high,
  input  wire logic [gdff_pkg::CHANNELS-1:0] sec_uv,
  input  wire logic                          prim_uv,
  output logic [gdff_pkg::CHANNELS-1:0]      gate_on,
  output logic [gdff_pkg::CHANNELS-1:0]      gate_neg,
  output logic [gdff_pkg::CHANNELS-1:0]      status_light,
  output logic                               so_out,
  output logic                               so_oe_n
);
  import gdff_pkg::*;

  initial begin
    if (RESP_CYC < 1 || ACK_CYC < 1 || CLEAR_CYC < 1 || SHUT_CYC < 1) $error("Timing counts must be nonzero.");
    if (RESP_CYC + SHUT_CYC >= (1 << CNT_W) || CLEAR_CYC >= (1 << CNT_W)) $error("Timing count too wide.");
    if (SHUT_CYC > CLEAR_CYC) $error("Shutdown delay must end inside clearing delay.");
  end

  // Supply status pin, independent of the channels.
  gdff_supply_status #(.HOLD(SO_HOLD)) u_so (  // [R10]
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .prim_uv  (prim_uv),
    .so_out   (so_out),
    .so_oe_n  (so_oe_n)
  );

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch  // [R12]
      gdff_state_t      st_reg;
      logic [CNT_W-1:0] cnt_reg;
      logic             in_reg;
      logic             gate_reg;
      logic             neg_reg;
      logic             light_reg;
      logic             ack_pulse;
      logic             edge_in;
      logic             rise_in;

      assign edge_in = drive_in[ch] ^ in_reg;
      assign rise_in = drive_in[ch] & ~in_reg;

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          in_reg <= 1'b0;
        end else if (clk_en) begin
          in_reg <= drive_in[ch];
        end
      end

      gdff_ack_pulse #(.CNT_W(CNT_W)) u_ack (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .trig     (edge_in),  // [R2]
        .ack_len  (CNT_W'(ACK_CYC)),
        .pulse    (ack_pulse)
      );

      // Channel sequencer.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          st_reg  <= GDFF_ST_OFF;
          cnt_reg <= '0;
        end else if (clk_en) begin
          if (sec_uv[ch]) begin
            st_reg  <= GDFF_ST_OFF;  // [R6]
            cnt_reg <= '0;
          end else begin
            unique case (st_reg)
              GDFF_ST_OFF: begin
                if (rise_in) begin  // [R5]
                  st_reg  <= GDFF_ST_RESP;  // [R13]
                  cnt_reg <= CNT_W'(RESP_CYC);
                end
              end
              GDFF_ST_RESP: begin
                if (!drive_in[ch]) begin
                  st_reg <= GDFF_ST_OFF;  // [R13]
                end else if (cnt_reg > CNT_W'(1)) begin
                  cnt_reg <= cnt_reg - 1'b1;
                end else if (vce_high[ch]) begin
                  st_reg  <= GDFF_ST_SHUT;  // [R14]
                  cnt_reg <= CNT_W'(SHUT_CYC);
                end else begin
                  st_reg <= GDFF_ST_ON;
                end
              end
              GDFF_ST_ON: begin
                if (!drive_in[ch]) begin
                  st_reg <= GDFF_ST_OFF;  // [R13]
                end
              end
              GDFF_ST_SHUT: begin
                if (cnt_reg > CNT_W'(1)) begin
                  cnt_reg <= cnt_reg - 1'b1;
                end else begin
                  st_reg  <= GDFF_ST_CLEAR;  // [R4]
                  cnt_reg <= CNT_W'(CLEAR_CYC - SHUT_CYC);
                end
              end
              GDFF_ST_CLEAR: begin
                if (cnt_reg > CNT_W'(1)) begin
                  cnt_reg <= cnt_reg - 1'b1;
                end else begin
                  st_reg <= GDFF_ST_OFF;  // [R3]
                end
              end
            endcase
          end
        end
      end

      // Gate and status outputs.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          gate_reg  <= 1'b0;
          neg_reg   <= 1'b1;
          light_reg <= 1'b0;  // [R7]
        end else if (clk_en) begin
          gate_reg  <= ~sec_uv[ch] & (st_reg == GDFF_ST_RESP || st_reg == GDFF_ST_ON || st_reg == GDFF_ST_SHUT);  // [R4]
          neg_reg   <= sec_uv[ch] | ~(st_reg == GDFF_ST_RESP || st_reg == GDFF_ST_ON || st_reg == GDFF_ST_SHUT);  // [R11]
          light_reg <= ~sec_uv[ch] & ~ack_pulse & (st_reg != GDFF_ST_SHUT) & (st_reg != GDFF_ST_CLEAR);  // [R1] [R3]
        end
      end

      assign gate_on[ch]      = gate_reg;
      assign gate_neg[ch]     = neg_reg;
      assign status_light[ch] = light_reg;
    end
  endgenerate
endmodule // gdff_top

// [verification/gdff_host.sv]
// Host side model: resolves the open-drain supply status pin.
// Assumes a pull-up on the pin at the host side.
`timescale 1ns/1ns
module gdff_host (
  input  wire logic so_out,
  input  wire logic so_oe_n,
  output logic      pin_level
);
  assign pin_level = so_oe_n ? 1'h1 : so_out;
endmodule // gdff_host

// [verification/gdff_sva.sv]
// Port-level timing checker for gdff_top.
// Assumes the shortened cycle counts of the bench are passed in.
`timescale 1ns/1ns
module gdff_sva #(
  parameter int unsigned SO_HOLD = 20
) (
  input wire logic                          core_clk,
  input wire logic                          rst_n,
  input wire logic [gdff_pkg::CHANNELS-1:0] drive_in,
  input wire logic [gdff_pkg::CHANNELS-1:0] sec_uv,
  input wire logic                          prim_uv,
  input wire logic [gdff_pkg::CHANNELS-1:0] gate_on,
  input wire logic [gdff_pkg::CHANNELS-1:0] gate_neg,
  input wire logic [gdff_pkg::CHANNELS-1:0] status_light,
  input wire logic                          so_out,
  input wire logic                          so_oe_n
);
  import gdff_pkg::*;
  localparam int SO_A = SO_HOLD - 8;
  localparam int SO_B = SO_HOLD - 6;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  neg_drive_a: assert property (gate_neg == ~gate_on) else $error("gate_neg not inverse");
  gate_off_a: assert property ($fell(drive_in[0]) |-> ##[1:10] !gate_on[0]) else $error("gate stayed on");
  ack_edge_a: assert property ($changed(drive_in[0]) |-> ##[1:3] !status_light[0]) else $error("no ack");
  sec_lock_a: assert property ($past(sec_uv[1]) && sec_uv[1] |-> !gate_on[1] && !status_light[1])
    else $error("undervoltage not locked");
  pin_low_a: assert property (prim_uv |=> !so_oe_n) else $error("pin not driven");
  pin_data_a: assert property (so_out == 1'h0) else $error("pin data high");
  pin_hold_a: assert property ($fell(prim_uv) |=> (!so_oe_n)[*8] ##[SO_A:SO_B] so_oe_n)
    else $error("pin release time");
  fault_dark_a: assert property ($fell(gate_on[0]) && drive_in[0] |-> !status_light[0])
    else $error("forced off while lit");
endmodule // gdff_sva
bind gdff_top gdff_sva #(.SO_HOLD(SO_HOLD)) sva_u (.core_clk, .rst_n, .drive_in, .sec_uv, .prim_uv, .gate_on,
  .gate_neg, .status_light, .so_out, .so_oe_n);

// [verification/testbench.sv]
// Self-checking bench for gdff_top with shortened counts.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ns
module testbench;
  import gdff_pkg::*;
  logic       core_clk, rst_n, clk_en, prim_uv, so_out, so_oe_n, pin;
  logic [1:0] drive_in, vce_high, sec_uv, gate_on, gate_neg, status_light;
  int         fail_count, num_checks, n, m;
  gdff_top #(.RESP_CYC(20), .ACK_CYC(5), .CLEAR_CYC(40), .SHUT_CYC(6), .SO_HOLD(20)) dut_u (.core_clk, .rst_n,
    .clk_en, .drive_in, .vce_high, .sec_uv, .prim_uv, .gate_on, .gate_neg, .status_light, .so_out, .so_oe_n);
  gdff_host host_u (.so_out, .so_oe_n, .pin_level(pin));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_for(int sel, logic v, output int k);
    k = 0;
    while ((sel == 0 ? status_light[0] : sel == 1 ? gate_on[0] : pin) !== v) begin
      @(negedge core_clk);
      k++;
      if (k > 200) begin
        fail_count++;
        give_verdict();
      end
    end
  endtask
  task automatic t_edge();
    drive_in = 2'h1;
    wait_for(1, 1'h1, n);
    chk("gate on delay", 2'h1, n <= 3);
    chk("other gate", 2'h0, gate_on[1]);
    wait_for(0, 1'h1, n);
    chk("ack width", 2'h1, n >= 3 && n <= 6);
    drive_in = 2'h0;
    repeat (3) @(negedge core_clk);
    chk("gate off", 2'h0, gate_on);
    repeat (10) @(negedge core_clk);
  endtask
  task automatic t_short();
    vce_high = 2'h1;
    drive_in = 2'h1;
    wait_for(0, 1'h0, n);
    wait_for(0, 1'h1, n);
    wait_for(0, 1'h0, n);
    chk("fault after check", 2'h1, n >= 12 && n <= 22);
    wait_for(1, 1'h0, n);
    chk("shut delay", 2'h1, n >= 5 && n <= 7);
    wait_for(0, 1'h1, m);
    chk("clear delay", 2'h1, n + m >= 39 && n + m <= 41);
    repeat (5) @(negedge core_clk);
    chk("no restart", 2'h0, gate_on);
    vce_high = 2'h0;
    drive_in = 2'h0;
    repeat (10) @(negedge core_clk);
    drive_in = 2'h1;
    repeat (3) @(negedge core_clk);
    chk("restart", 2'h1, gate_on);
    drive_in = 2'h0;
    repeat (10) @(negedge core_clk);
  endtask
  task automatic t_uv();
    drive_in = 2'h3;
    repeat (10) @(negedge core_clk);
    sec_uv = 2'h2;
    prim_uv = 1'h1;
    repeat (30) @(negedge core_clk);
    chk("uv gates", 2'h1, gate_on);
    chk("uv negative", 2'h2, gate_neg);
    chk("uv light", 2'h1, status_light);
    chk("pin low", 2'h0, pin);
    prim_uv = 1'h0;
    wait_for(2, 1'h1, n);
    chk("pin release", 2'h1, n >= 19 && n <= 22);
    sec_uv = 2'h0;
    drive_in = 2'h0;
    repeat (60) @(negedge core_clk);
  endtask
  task automatic t_freeze();
    clk_en = 1'h0;
    drive_in = 2'h2;
    repeat (5) @(negedge core_clk);
    chk("frozen gate", 2'h0, gate_on);
    clk_en = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("thawed gate", 2'h2, gate_on);
    drive_in = 2'h0;
    repeat (10) @(negedge core_clk);
  endtask
  initial begin
    {rst_n, clk_en, prim_uv, drive_in, vce_high, sec_uv} = 9'h080;
    fail_count = 0;
    num_checks = 0;
    repeat (16) @(negedge core_clk);
    chk("reset light", 2'h0, status_light);
    chk("reset gate", 2'h3, gate_neg);
    rst_n = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("light ok", 2'h3, status_light);
    chk("pin idle", 2'h1, pin);
    t_edge();
    t_short();
    t_uv();
    t_freeze();
    give_verdict();
  end
endmodule // testbench
